// file: hw/adc_sync_pkg.sv
// Purpose: Shared constants and types for converter rate and start control
// Assumes: 100 MHz system clock; all pins are asynchronous to it
// Notes: Timing figures are kept in their own units and converted to cycles
// Notes on behaviour
// - Modulator runs at 256 times notch frequency
// - Internal 153.6kHz gives 60Hz, 7.5 results/s
// - Static low picks 60Hz, high picks 50Hz
// - External clock: one result per 20480 cycles
// - 2.048MHz external gives 800Hz notch, 100/s
// - Each result independent of previous conversion
// - Chip-select rising edge starts a conversion
// - 24th serial-clock falling edge starts conversion
package adc_sync_pkg;

    // ****************************************
    // Clock rates and ratios
    // ****************************************
    localparam logic [26:0] SYS_HZ = 27'h5f5_e100;       // 100 MHz system clock
    localparam logic [26:0] INT60_HZ = 27'h002_5800;     // 153.6 kHz oscillator, 60 Hz notch
    localparam logic [26:0] INT50_HZ = 27'h001_f400;     // 128 kHz oscillator, 50 Hz notch
    localparam logic [14:0] MASTER_PER_CONV = 15'h5000;  // Master cycles per result
    localparam logic [3:0] MOD_DIV = 4'ha;               // Master cycles per modulator sample
    localparam logic [11:0] MOD_PER_CONV = 12'h800;      // Modulator samples per result
    localparam logic [4:0] SCK_START_EDGE = 5'h18;       // Falling edge that autostarts

    // ****************************************
    // Toggle detection window
    // ****************************************
    localparam int EXT_QUIET_US = 100;                   // Quiet time before static level counts
    localparam int SYS_MHZ = 100;                        // Cycles per microsecond
    localparam int EXT_QUIET_CYC = EXT_QUIET_US * SYS_MHZ;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {MODE_INT60, MODE_INT50, MODE_EXT} conv_mode_t;  // Clock source

    typedef struct packed {
        conv_mode_t mode;           // Source used for this result
        logic [11:0] mod_ticks;     // Modulator samples taken
        logic [14:0] master_ticks;  // Master cycles spanned
    } result_t;

endpackage

// file: hw/result_buffer.sv
// Purpose: Two-entry result buffer with valid and ready on both sides
// Assumes: Single clock domain, asynchronous active-low reset
// Notes: All outputs come from flip-flops; nothing is lost on a stall
`timescale 1ns/1ps
module result_buffer #(
    parameter int WIDTH = 29
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    // ****************************************
    // State
    // ****************************************
    logic [WIDTH-1:0] head_r, head_nxt;  // Oldest word, drives output
    logic [WIDTH-1:0] tail_r, tail_nxt;  // Second word
    logic head_v_r, head_v_nxt;          // Head holds a word
    logic tail_v_r, tail_v_nxt;          // Tail holds a word

    if (WIDTH < 1) begin : g_bad_width
        $error("result_buffer needs a positive width");
    end

    // Push and pop bookkeeping
    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        push = in_valid && !tail_v_r;
        pop = head_v_r && out_ready;
        head_r_hold: begin
            head_nxt = head_r;
            tail_nxt = tail_r;
            head_v_nxt = head_v_r;
            tail_v_nxt = tail_v_r;
        end
        if (pop) begin
            // Tail moves up, or new word lands directly
            head_nxt = tail_v_r ? tail_r : in_data;
            head_v_nxt = tail_v_r || push;
            tail_v_nxt = tail_v_r && push;
            tail_nxt = in_data;
        end else if (push) begin
            if (head_v_r) begin
                tail_nxt = in_data;
                tail_v_nxt = 1'b1;
            end else begin
                head_nxt = in_data;
                head_v_nxt = 1'b1;
            end
        end
    end

    // Register only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            head_r <= '0;
            tail_r <= '0;
            head_v_r <= 1'b0;
            tail_v_r <= 1'b0;
        end else begin
            head_r <= head_nxt;
            tail_r <= tail_nxt;
            head_v_r <= head_v_nxt;
            tail_v_r <= tail_v_nxt;
        end
    end

    assign in_ready = !tail_v_r;
    assign out_valid = head_v_r;
    assign out_data = head_r;

endmodule

// file: hw/adc_rate_and_conversion_sync.sv
// Purpose: Conversion timing for a delta-sigma converter: clock source, rate, start
// Assumes: notch_freq_select, cs_n and sck are pins, sampled by sys_clk
// Notes: Results queue in a two-entry buffer; a full buffer holds the finished result back until a slot frees or a new start drops it
`timescale 1ns/1ps
module adc_rate_and_conversion_sync #(
    parameter int EXT_QUIET_CYC = adc_sync_pkg::EXT_QUIET_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic notch_freq_select,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic res_ready,
    output logic res_valid,
    output adc_sync_pkg::result_t res_data,
    output logic conv_busy,
    output logic ext_clk_mode,
    output logic mod_tick
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (EXT_QUIET_CYC < 16 || EXT_QUIET_CYC > 1000000) begin : g_bad_quiet
        $error("EXT_QUIET_CYC out of range");
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] f0_sync_r;   // Two stages plus history
    logic [2:0] cs_sync_r;   // Two stages plus history
    logic [2:0] sck_sync_r;  // Two stages plus history

    // Only stages 1 and 2 are read by logic
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            f0_sync_r <= '0;
            cs_sync_r <= 3'h7;
            sck_sync_r <= '0;
        end else begin
            f0_sync_r <= {f0_sync_r[1:0], notch_freq_select};
            cs_sync_r <= {cs_sync_r[1:0], cs_n};
            sck_sync_r <= {sck_sync_r[1:0], sck};
        end
    end

    logic f0_lvl;     // Synchronised select level
    logic f0_edge;    // Any toggle of select pin
    logic f0_rise;    // Rising edge of external clock
    logic cs_rise;    // Chip-select released
    logic cs_low;     // Chip-select asserted
    logic sck_fall;   // Serial clock falling edge
    assign f0_lvl = f0_sync_r[1];
    assign f0_edge = f0_sync_r[1] ^ f0_sync_r[2];
    assign f0_rise = f0_sync_r[1] && !f0_sync_r[2];
    assign cs_rise = cs_sync_r[1] && !cs_sync_r[2];
    assign cs_low = !cs_sync_r[1];
    assign sck_fall = !sck_sync_r[1] && sck_sync_r[2];

    // ****************************************
    // Clock source selection and master tick
    // ****************************************
    adc_sync_pkg::conv_mode_t mode_r, mode_nxt;  // Current clock source
    logic [19:0] quiet_r, quiet_nxt;             // Cycles since last select toggle
    logic [26:0] nco_r, nco_nxt;                 // Internal oscillator phase
    logic master_r, master_nxt;                  // One-cycle master clock tick
    logic ext_r, ext_nxt;                        // External mode flag, drives output

    always_comb begin
        logic [27:0] sum;
        logic [26:0] rate;
        sum = '0;
        rate = '0;
        quiet_nxt = quiet_r;
        mode_nxt = mode_r;
        // Toggling select switches to the external clock
        if (f0_edge) begin
            quiet_nxt = '0;
            mode_nxt = adc_sync_pkg::MODE_EXT;
        end else if (quiet_r >= 20'(EXT_QUIET_CYC - 1)) begin
            // Static level picks the notch
            mode_nxt = f0_lvl ? adc_sync_pkg::MODE_INT50 : adc_sync_pkg::MODE_INT60;
        end else begin
            quiet_nxt = quiet_r + 20'h0_0001;
        end
        // Internal oscillator as a fractional divider of the system clock
        rate = (mode_r == adc_sync_pkg::MODE_INT50) ? adc_sync_pkg::INT50_HZ : adc_sync_pkg::INT60_HZ;
        sum = {1'b0, nco_r} + {1'b0, rate};
        nco_nxt = nco_r;
        master_nxt = 1'b0;
        if (mode_r == adc_sync_pkg::MODE_EXT) begin
            nco_nxt = '0;
            master_nxt = f0_rise;
        end else if (sum >= {1'b0, adc_sync_pkg::SYS_HZ}) begin
            nco_nxt = 27'(sum - {1'b0, adc_sync_pkg::SYS_HZ});
            master_nxt = 1'b1;
        end else begin
            nco_nxt = sum[26:0];
        end
        // Output flag follows the next source so it leaves a flip-flop
        ext_nxt = (mode_nxt == adc_sync_pkg::MODE_EXT);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= adc_sync_pkg::MODE_INT60;
            quiet_r <= '0;
            nco_r <= '0;
            master_r <= 1'b0;
            ext_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            quiet_r <= quiet_nxt;
            nco_r <= nco_nxt;
            master_r <= master_nxt;
            ext_r <= ext_nxt;
        end
    end

    // ****************************************
    // Start detection
    // ****************************************
    logic [4:0] sck_cnt_r, sck_cnt_nxt;  // Falling edges in this readout
    logic start;                         // Begin a fresh conversion

    always_comb begin
        sck_cnt_nxt = sck_cnt_r;
        if (!cs_low) begin
            sck_cnt_nxt = '0;
        end else if (sck_fall && sck_cnt_r != 5'h1f) begin
            sck_cnt_nxt = sck_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sck_cnt_r <= '0;
        end else begin
            sck_cnt_r <= sck_cnt_nxt;
        end
    end

    // Chip-select release or autostart edge
    assign start = cs_rise
        || (cs_low && sck_fall && sck_cnt_r == adc_sync_pkg::SCK_START_EDGE - 5'h01);

    // ****************************************
    // Conversion sequencer
    // ****************************************
    typedef enum {ST_IDLE, ST_CONV, ST_HAND} conv_state_t;
    conv_state_t state_r, state_nxt;           // Sequencer state
    logic [14:0] mcnt_r, mcnt_nxt;             // Master ticks in this conversion
    logic [3:0] div_r, div_nxt;                // Modulator divider phase
    logic [11:0] modcnt_r, modcnt_nxt;         // Modulator samples taken
    logic mod_r, mod_nxt;                      // Modulator sample pulse
    adc_sync_pkg::result_t res_r, res_nxt;     // Finished result
    logic buf_ready;                           // Buffer can take a word
    logic busy_r, busy_nxt;                    // Converting flag, drives output

    always_comb begin
        state_nxt = state_r;
        mcnt_nxt = mcnt_r;
        div_nxt = div_r;
        modcnt_nxt = modcnt_r;
        mod_nxt = 1'b0;
        res_nxt = res_r;
        case (state_r)
            ST_IDLE: begin
                // Sleep until a start
            end
            ST_CONV: begin
                if (master_r) begin
                    mcnt_nxt = mcnt_r + 15'h0001;
                    // Modulator sample every tenth master tick
                    if (div_r == adc_sync_pkg::MOD_DIV - 4'h1) begin
                        div_nxt = '0;
                        mod_nxt = 1'b1;
                        modcnt_nxt = modcnt_r + 12'h001;
                    end else begin
                        div_nxt = div_r + 4'h1;
                    end
                    // Last master tick closes the conversion
                    if (mcnt_r == adc_sync_pkg::MASTER_PER_CONV - 15'h0001) begin
                        state_nxt = ST_HAND;
                        res_nxt.mode = mode_r;
                        res_nxt.mod_ticks = modcnt_r + 12'h001;
                        res_nxt.master_ticks = mcnt_r + 15'h0001;
                    end
                end
            end
            ST_HAND: begin
                // Hold result until buffer accepts it
                if (buf_ready) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // A start always wins and clears all conversion history
        if (start) begin
            state_nxt = ST_CONV;
            mcnt_nxt = '0;
            div_nxt = '0;
            modcnt_nxt = '0;
        end
        // Busy flag registered from the next state, no decode on the pin
        busy_nxt = (state_nxt == ST_CONV);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            mcnt_r <= '0;
            div_r <= '0;
            modcnt_r <= '0;
            mod_r <= 1'b0;
            res_r <= '0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mcnt_r <= mcnt_nxt;
            div_r <= div_nxt;
            modcnt_r <= modcnt_nxt;
            mod_r <= mod_nxt;
            res_r <= res_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ****************************************
    // Result buffer and outputs
    // ****************************************
    result_buffer #(
        .WIDTH($bits(adc_sync_pkg::result_t))
    ) u_buf (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(state_r == ST_HAND && !start),
        .in_ready(buf_ready),
        .in_data(res_r),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );

    assign conv_busy = busy_r;
    assign ext_clk_mode = ext_r;
    assign mod_tick = mod_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic [10:0] gap_r;   // Cycles since last master tick, internal or external
    logic gap_ok_r;       // Gap measured under one stable source
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gap_r <= '0;
            gap_ok_r <= 1'b0;
        end else begin
            gap_r <= master_r ? 11'h000 : gap_r + 11'h001;
            gap_ok_r <= (mode_r == mode_nxt) && (gap_ok_r || master_r);
        end
    end

    chk_mod_count: assert property (state_r == ST_CONV && state_nxt == ST_HAND && !start
        |=> res_r.mod_ticks == 12'h800) else $error("modulator sample count per result wrong");
    chk_int60_gap: assert property (master_r && gap_ok_r && mode_r == adc_sync_pkg::MODE_INT60
        |-> gap_r == 11'h28a || gap_r == 11'h28b) else $error("60 Hz oscillator period wrong");
    chk_int50_gap: assert property (master_r && gap_ok_r && mode_r == adc_sync_pkg::MODE_INT50
        |-> gap_r == 11'h30c || gap_r == 11'h30d) else $error("50 Hz oscillator period wrong");
    chk_conv_length: assert property (state_r == ST_CONV && state_nxt == ST_HAND && !start
        |=> res_r.master_ticks == 15'h5000) else $error("master cycles per result wrong");
    chk_ext_divide: assert property (mod_r |-> $past(div_r) == 4'h9 && $past(master_r))
        else $error("modulator not master divided by ten");
    chk_start_clears: assert property (start |=> mcnt_r == 15'h0000 && modcnt_r == 12'h000)
        else $error("conversion history survived a start");
    chk_cs_start: assert property ($rose(cs_sync_r[1]) |=> state_r == ST_CONV && mcnt_r == 15'h0000)
        else $error("chip-select release did not start");
    chk_sck_auto: assert property (cs_low && sck_fall && sck_cnt_r == 5'h17 |=> state_r == ST_CONV)
        else $error("24th falling edge did not start");
    chk_toggle_ext: assert property (f0_edge |=> ext_clk_mode)
        else $error("toggling select did not pick external clock");
    chk_ext_tick: assert property (mode_r == adc_sync_pkg::MODE_EXT && f0_rise |=> master_r)
        else $error("external rising edge gave no master tick");

endmodule

// file: test/ctrl_model.sv
// Purpose: Serial controller model driving chip select, serial clock and rate select
// Assumes: Pins are asynchronous to the converter's system clock
// Notes: Serial clock idles low and moves only inside frames
`timescale 1ns/1ps
module ctrl_model (
    output logic cs_n,
    output logic sck,
    output logic notch_freq_select
);
    // ****************************************
    // Pin state
    // ****************************************
    logic ext_on;     // Master clock running
    logic static_lvl; // Level used when master clock is off

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        notch_freq_select = 1'b0;
        ext_on = 1'b0;
        static_lvl = 1'b0;
    end

    // ****************************************
    // Shared master clock, 20 ns period
    // ****************************************
    always begin
        #10;
        if (ext_on) begin
            notch_freq_select = ~notch_freq_select;
        end else begin
            notch_freq_select = static_lvl;
        end
    end

    // Opens a frame with chip select low
    task automatic select();
        cs_n = 1'b0;
        #37;
    endtask

    // Gives serial clock pulses, 80 ns period, phase free of the system clock
    task automatic clocks(input int edges);
        repeat (edges) begin
            sck = 1'b1;
            #40;
            sck = 1'b0;
            #40;
        end
    endtask

    // Ends a frame; the rising chip select is the start request
    task automatic release_cs();
        cs_n = 1'b1;
    endtask
endmodule

// file: test/adc_rate_and_conversion_sync_test.sv
// Purpose: Self-checking bench for conversion rate and start control
// Assumes: Quiet window shortened to 64 cycles; master clock at 50 MHz
// Notes: Expected words are queued by the driver and checked by a monitor
`timescale 1ns/1ps
module adc_rate_and_conversion_sync_test;
    // ****************************************
    // Signals
    // ****************************************
    localparam int QUIET = 64;          // Shortened quiet window
    logic sys_clk;                      // 100 MHz clock
    logic rstn;                         // Active-low reset
    logic res_ready;                    // Consumer ready
    logic cs_n, sck, notch_freq_select; // Pins from the controller
    logic res_valid, conv_busy, ext_clk_mode, mod_tick;
    adc_sync_pkg::result_t res_data;    // Result word
    adc_sync_pkg::result_t exp_q[$];    // Expected words in order
    int failures;                       // Mismatch count
    int cmp_count;                      // Comparison count

    ctrl_model u_ctrl_model (.cs_n(cs_n), .sck(sck), .notch_freq_select(notch_freq_select));

    adc_rate_and_conversion_sync #(.EXT_QUIET_CYC(QUIET)) u_adc_rate_and_conversion_sync (
        .sys_clk(sys_clk), .rstn(rstn), .notch_freq_select(notch_freq_select), .cs_n(cs_n),
        .sck(sck), .res_ready(res_ready), .res_valid(res_valid), .res_data(res_data),
        .conv_busy(conv_busy), .ext_clk_mode(ext_clk_mode), .mod_tick(mod_tick)
    );

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    // ****************************************
    // Helpers
    // ****************************************
    // Compares and counts
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // Prints counts and verdict, ends the run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Selects one watched output
    function automatic logic sig(input int sel);
        case (sel)
            0: return conv_busy;
            1: return mod_tick;
            2: return ext_clk_mode;
            default: return res_valid;
        endcase
    endfunction

    // Bounded wait for an output level; n is cycles taken
    task automatic wait_for(input int sel, input logic lvl, input int limit, output int n);
        n = 0;
        while (sig(sel) !== lvl) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > limit) begin
                check(0, 1, "wait bound");
                stop_test();
            end
        end
    endtask

    // Cycles between two modulator pulses
    task automatic tick_gap(output int n);
        int k;
        // Skip the cycle of a pulse that may still stand
        @(posedge sys_clk);
        #1;
        wait_for(1, 1'b1, 9000, k);
        @(posedge sys_clk);
        #1;
        wait_for(1, 1'b1, 9000, n);
        n++;
    endtask

    // Reset held six cycles
    task automatic do_reset();
        rstn = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        check({res_valid, conv_busy, ext_clk_mode, mod_tick, res_data}, 0, "reset outputs");
        rstn = 1'b1;
    endtask

    // ****************************************
    // Monitor: each taken word against the oldest note
    // ****************************************
    always @(posedge sys_clk) begin
        if (rstn && res_valid === 1'b1 && res_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(0, 1, "extra result");
            end else begin
                check(res_data, exp_q.pop_front(), "result word");
            end
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int n, k, e;
        adc_sync_pkg::result_t w;
        failures = 0;
        cmp_count = 0;
        rstn = 1'b0;
        res_ready = 1'b0;
        w = '{mode: adc_sync_pkg::MODE_EXT, mod_ticks: adc_sync_pkg::MOD_PER_CONV,
              master_ticks: adc_sync_pkg::MASTER_PER_CONV};
        k = $urandom(56182);
        do_reset();
        // Short frame then chip-select start
        k = 1 + $urandom % 23;
        u_ctrl_model.select();
        u_ctrl_model.clocks(k);
        repeat (10) @(posedge sys_clk);
        #1;
        check(conv_busy, 0, "short frame start");
        u_ctrl_model.release_cs();
        wait_for(0, 1'b1, 6, n);
        check(n, 3, "chip select start");
        $display("test start by chip select done");
        // Internal rates, low then high level
        tick_gap(n);
        e = int'(adc_sync_pkg::SYS_HZ) * 10 / int'(adc_sync_pkg::INT60_HZ);
        check(n >= e - 2 && n <= e + 2, 1, "60 Hz modulator rate");
        u_ctrl_model.static_lvl = 1'b1;
        tick_gap(n);
        e = int'(adc_sync_pkg::SYS_HZ) * 10 / int'(adc_sync_pkg::INT50_HZ);
        check(n >= e - 2 && n <= e + 2, 1, "50 Hz modulator rate");
        $display("test internal rates done");
        // Mid-run reset, then autostart on the 24th fall
        // Pin settles low inside reset, so no false edge follows it
        u_ctrl_model.static_lvl = 1'b0;
        do_reset();
        u_ctrl_model.select();
        u_ctrl_model.clocks(adc_sync_pkg::SCK_START_EDGE);
        check(conv_busy, 1, "autostart");
        u_ctrl_model.release_cs();
        $display("test autostart done");
        // Master clock taken over, restart gives a clean word
        u_ctrl_model.ext_on = 1'b1;
        wait_for(2, 1'b1, 10, n);
        check(ext_clk_mode, 1, "external mode");
        tick_gap(n);
        check(n, 20, "external modulator rate");
        @(posedge sys_clk);
        #1;
        u_ctrl_model.select();
        exp_q.push_back(w);
        u_ctrl_model.release_cs();
        wait_for(3, 1'b1, 42000, n);
        repeat (50) @(posedge sys_clk);
        #1;
        check(res_valid, 1, "word stands while stalled");
        // Second word by autostart, receiver still stalled
        u_ctrl_model.select();
        exp_q.push_back(w);
        u_ctrl_model.clocks(24);
        wait_for(0, 1'b0, 42000, n);
        repeat (5) @(posedge sys_clk);
        for (k = 0; k < 300 && exp_q.size() != 0; k++) begin
            @(posedge sys_clk);
            #1;
            res_ready = 1'($urandom % 2);
        end
        repeat (3) @(posedge sys_clk);
        #1;
        check(exp_q.size(), 0, "all words drained");
        check(res_valid, 0, "buffer empty");
        $display("test external conversions done");
        // Master clock stops, static level takes over after the quiet time
        u_ctrl_model.ext_on = 1'b0;
        wait_for(2, 1'b0, 200, n);
        check(n >= QUIET - 5 && n <= QUIET + 10, 1, "leave external mode");
        u_ctrl_model.release_cs();
        $display("test mode exit done");
        stop_test();
    end
endmodule
